// file: core/lcd_pkg.sv
// Constants, register map and types for the segment LCD control block
package lcd_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned HCLK_HZ        = 100_000_000;
  localparam int unsigned SEG_CLK_HZ     = 32_768;
  localparam int unsigned SEG_DIV        = HCLK_HZ / SEG_CLK_HZ;
  localparam logic [11:0] SEG_DIV_LAST   = 12'(SEG_DIV - 1);
  // Segment clock ticks spent in each backplane phase
  localparam logic [3:0]  PHASE_TICKS_LAST = 4'h7;
  localparam logic [4:0]  BLINK_BASE_BIT = 5'h0B;
  localparam int unsigned BLINK_CNT_W    = 19;

  // ****************************************************************
  // Register map (byte addresses, low 12 bits decoded)
  // ****************************************************************
  localparam logic [11:0] OFS_BLINK   = 12'h000;
  localparam logic [11:0] OFS_STATUS  = 12'h004;
  localparam logic [11:0] OFS_CONFIG  = 12'h008;
  localparam logic [6:0]  PEN_WIN     = 7'h01;
  localparam logic [6:0]  BPS_WIN     = 7'h02;
  localparam logic [3:0]  PAT_WIN     = 4'h1;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int unsigned BLINK_EN_BIT   = 7;
  localparam int unsigned ALT_BIT        = 6;
  localparam int unsigned BLANK_BIT      = 5;
  localparam int unsigned CONTENT_BIT    = 3;
  localparam int unsigned FLAG_BIT       = 7;
  localparam int unsigned DRV_ON_BIT     = 7;
  localparam int unsigned IRQ_EN_BIT     = 6;
  localparam logic [7:0]  BLINK_CTRL_RST = 8'h00;
  localparam logic [7:0]  CONFIG_RST     = 8'h03;
  localparam logic [63:0] PIN_VEC_RST    = 64'h0;
  localparam logic [2:0]  ALT_MAX_DUTY   = 3'h3;
  localparam logic [2:0]  ALT_PHASE_OFS  = 3'h4;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ  = 2'b10
  } bus_state_t;

endpackage

// file: core/pattern_mem.sv
// Per-pin pattern byte memory, one write port and two registered reads
module pattern_mem (
  input  wire logic    hclk,
  pattern_mem_if.mem   port
);

  typedef struct packed {
    logic [7:0] bus_rdata;
    logic [7:0] scan_rdata;
  } mem_state_t;

  // No reset here: contents stay undefined until software writes them
  logic [7:0] store [64];
  mem_state_t r_reg;
  mem_state_t r_next;

  always_comb begin
    r_next = r_reg;
    // Write-first so a read right after a write sees the new byte
    if (port.wr_en && port.wr_idx == port.bus_idx) begin
      r_next.bus_rdata = port.wr_data;
    end else begin
      r_next.bus_rdata = store[port.bus_idx];
    end
    r_next.scan_rdata = store[port.scan_idx];
  end

  always_ff @(posedge hclk) begin
    r_reg <= r_next;
    if (port.wr_en) begin
      store[port.wr_idx] <= port.wr_data;  // see R16
    end
  end

  assign port.bus_rdata  = r_reg.bus_rdata;
  assign port.scan_rdata = r_reg.scan_rdata;

endmodule

// file: core/pattern_mem_if.sv
// Ports between the controller and the pattern byte memory
interface pattern_mem_if;
  logic       wr_en;
  logic [5:0] wr_idx;
  logic [7:0] wr_data;
  logic [5:0] bus_idx;
  logic [7:0] bus_rdata;
  logic [5:0] scan_idx;
  logic [7:0] scan_rdata;

  modport ctrl (
    output wr_en,
    output wr_idx,
    output wr_data,
    output bus_idx,
    output scan_idx,
    input  bus_rdata,
    input  scan_rdata
  );

  modport mem (
    input  wr_en,
    input  wr_idx,
    input  wr_data,
    input  bus_idx,
    input  scan_idx,
    output bus_rdata,
    output scan_rdata
  );
endinterface

// file: core/segment_lcd_blink_pattern_ctrl.sv
// Segment LCD control: registers, blink, display modes and pin sequencing
//
// What this block does
// R1 - Blink bit 7 starts blinking; clearing it restores the normal display.
// R2 - Second-image select shows the alternate image at duty four or less.
// R3 - Blank bit 5 turns every segment off whatever the patterns hold.
// R4 - Content bit 3 in blink half: 0 blank, 1 alternate, unless duty five+.
// R5 - Blink frequency is segment clock over two to the (12 + rate).
// R6 - Status flag bit 7 sets on the event; only writing 1 clears it.
// R7 - Each of 64 pin enables puts its pin under LCD control while driver on.
// R8 - With the driver off, pin enables and backplane selects touch no pin.
// R9 - Backplane select per enabled pin: 1 backplane, 0 frontplane.
// R10 - Software programs pin enables before switching the driver on.
// R11 - Software should set backplane selects before switching the driver on.
// R12 - Software writes pin, select and pattern registers one byte at a time.
// R13 - Frontplane pattern bit lights the segment to that phase's backplane.
// R14 - Backplane pattern bit marks the pin active in that phase A to H.
// R15 - Pattern byte bit 7 is phase H down to bit 0 phase A, per pin.
// R16 - Reset leaves pattern bytes undefined until software writes them.
// R17 - Pin enable registers keep their contents through retained stop.
// R18 - Backplane select registers keep their contents through retained stop.
// R19 - Three-bit duty selects one to eight backplanes; reset gives four.
// R20 - With frame interrupt enabled, each frame start sets the status flag.
// R21 - Blank mode does not use pattern bytes for segment drive.
// R22 - Blinking alternates normal and blink content, half period each.
// R23 - Frame interrupt stays high while flag and enable are both set.
//
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
module segment_lcd_blink_pattern_ctrl
  import lcd_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic [63:0]      pin_lcd_active,
  output logic [63:0]      pin_backplane,
  output logic [63:0]      pin_level,
  output logic [2:0]       drive_phase,
  output logic             frame_irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    bus_state_t              bus;
    logic [11:0]             addr;
    logic                    hready;
    logic [31:0]             rdata;
    logic                    hresp;
    logic [7:0]              blink_ctrl;
    logic                    flag;
    logic [7:0]              config_b;
    logic [63:0]             pen;
    logic [63:0]             bps;
    logic [11:0]             seg_div;
    logic [3:0]              tick;
    logic [2:0]              phase;
    logic [BLINK_CNT_W-1:0]  blink_cnt;
    logic                    scan_busy;
    logic [6:0]              scan_cnt;
    logic [2:0]              scan_bit;
    logic                    scan_blank;
    logic [63:0]             shadow;
    logic [63:0]             out_lcd;
    logic [63:0]             out_bp;
    logic [63:0]             out_level;
    logic                    irq;
  } state_t;

  state_t        r_reg;
  state_t        r_next;
  pattern_mem_if mem_port ();

  pattern_mem u_pattern_mem (
    .hclk (hclk),
    .port (mem_port.mem)
  );

  // ****************************************************************
  // Decoded controls
  // ****************************************************************
  logic        drv_on;
  logic [2:0]  duty;
  logic        alt_ok;
  logic        blink_half;
  logic        blink_shown;
  logic        show_alt;
  logic        show_blank;
  logic [4:0]  half_bit;
  logic [63:0] lvl_vec;
  logic        accept;
  logic        wr_pat;
  logic        flash_on;
  logic        blank_on;
  logic        second_image_select;
  logic        flash_content_select;
  logic [2:0]  flash_rate_select;
  logic        frame_event_irq_enable;
  logic        hit_blink;
  logic        hit_status;
  logic        hit_config;
  logic        hit_pen;
  logic        hit_bps;
  logic        hit_pat;
  logic [63:0] lcd_vec;
  logic [63:0] bp_vec;

  assign drv_on   = r_reg.config_b[DRV_ON_BIT];
  assign duty     = r_reg.config_b[2:0];
  assign frame_event_irq_enable = r_reg.config_b[IRQ_EN_BIT];
  assign flash_on             = r_reg.blink_ctrl[BLINK_EN_BIT];
  assign second_image_select  = r_reg.blink_ctrl[ALT_BIT];
  assign blank_on             = r_reg.blink_ctrl[BLANK_BIT];
  assign flash_content_select = r_reg.blink_ctrl[CONTENT_BIT];
  assign flash_rate_select    = r_reg.blink_ctrl[2:0];
  assign alt_ok   = (duty <= ALT_MAX_DUTY);                    // see R2
  assign half_bit = BLINK_BASE_BIT + {2'b00, flash_rate_select};
  // Half of a 2^(12+rate) tick period is bit 11+rate of the count
  assign blink_half  = r_reg.blink_cnt[half_bit];              // see R5
  assign blink_shown = flash_on & blink_half;                  // see R22
  // Content select 1 at high duty falls back to blank
  assign show_alt = alt_ok & (blink_shown ?
                    flash_content_select :                     // see R4
                    second_image_select);                      // see R2
  assign show_blank = blank_on |                               // see R3
                      (blink_shown &
                       ~(flash_content_select & alt_ok));      // see R1

  assign accept = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign wr_pat = (r_reg.bus == BUS_WRITE) && hit_pat;

  assign mem_port.wr_en    = wr_pat;
  assign mem_port.wr_idx   = r_reg.addr[7:2];
  assign mem_port.wr_data  = hwdata[7:0];
  assign mem_port.bus_idx  = haddr[7:2];
  assign mem_port.scan_idx = r_reg.scan_cnt[5:0];

  // ****************************************************************
  // Data-phase address decode
  // ****************************************************************
  // Whole-offset compares for blink, status and config; the pin and pattern windows ignore addr bits 1:0, other holes read zero
  assign hit_blink  = (r_reg.addr == OFS_BLINK);
  assign hit_status = (r_reg.addr == OFS_STATUS);
  assign hit_config = (r_reg.addr == OFS_CONFIG);
  assign hit_pen    = (r_reg.addr[11:5] == PEN_WIN);
  assign hit_bps    = (r_reg.addr[11:5] == BPS_WIN);
  assign hit_pat    = (r_reg.addr[11:8] == PAT_WIN);

  // ****************************************************************
  // Per-pin drive level
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 64; gi++) begin : g_pin
      // Blank only silences frontplanes, backplanes keep sequencing
      assign lvl_vec[gi] = drv_on & r_reg.pen[gi] & r_reg.shadow[gi] &
                           (r_reg.bps[gi] | ~r_reg.scan_blank); // see R21
      assign lcd_vec[gi] = drv_on & r_reg.pen[gi];             // see R7 R8
      assign bp_vec[gi]  = lcd_vec[gi] & r_reg.bps[gi];        // see R9
    end
  endgenerate

  // ****************************************************************
  // Register read mux
  // ****************************************************************
  function automatic logic [7:0] reg_read(input state_t s,
                                          input logic [7:0] pat);
    logic [7:0] v;
    v = 8'h00;
    if (s.addr == OFS_BLINK) begin
      v = s.blink_ctrl;
    end else if (s.addr == OFS_STATUS) begin
      v = {s.flag, 7'h00};
    end else if (s.addr == OFS_CONFIG) begin
      v = s.config_b;
    end else if (s.addr[11:5] == PEN_WIN) begin
      v = s.pen[{s.addr[4:2], 3'h0} +: 8];
    end else if (s.addr[11:5] == BPS_WIN) begin
      v = s.bps[{s.addr[4:2], 3'h0} +: 8];
    end else if (s.addr[11:8] == PAT_WIN) begin
      v = pat;
    end
    return v;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic       seg_tick;
    logic       step;
    logic       frame_start;
    logic       flag_clr;
    logic [5:0] cap_pin;
    seg_tick    = 1'b0;
    step        = 1'b0;
    frame_start = 1'b0;
    flag_clr    = 1'b0;
    cap_pin     = 6'(r_reg.scan_cnt - 7'h01);
    r_next      = r_reg;
    r_next.hresp = 1'b0;

    // Bus data phase
    unique case (r_reg.bus)
      BUS_WRITE: begin
        if (hit_blink) begin
          r_next.blink_ctrl = hwdata[7:0];
        end else if (hit_status) begin
          flag_clr = hwdata[FLAG_BIT];                         // see R6
        end else if (hit_config) begin
          r_next.config_b = hwdata[7:0];
        end else if (hit_pen) begin
          r_next.pen[{r_reg.addr[4:2], 3'h0} +: 8] = hwdata[7:0]; // see R7
        end else if (hit_bps) begin
          r_next.bps[{r_reg.addr[4:2], 3'h0} +: 8] = hwdata[7:0]; // see R9
        end
        r_next.bus = BUS_IDLE;
      end
      BUS_READ: begin
        r_next.rdata  = {24'h000000, reg_read(r_reg, mem_port.bus_rdata)};
        r_next.hready = 1'b1;
        r_next.bus    = BUS_IDLE;
      end
      BUS_IDLE: begin
        r_next.bus = BUS_IDLE;
      end
      default: begin
        r_next.bus = BUS_IDLE;
      end
    endcase

    // Bus address phase
    if (accept) begin
      r_next.addr   = haddr[11:0];
      r_next.bus    = hwrite ? BUS_WRITE : BUS_READ;
      r_next.hready = hwrite;
    end

    // Segment clock enable and phase sequencer
    if (drv_on) begin
      if (r_reg.seg_div == SEG_DIV_LAST) begin
        r_next.seg_div = 12'h000;
        seg_tick       = 1'b1;
      end else begin
        r_next.seg_div = r_reg.seg_div + 12'h001;
      end
      if (seg_tick) begin
        if (r_reg.tick == PHASE_TICKS_LAST) begin
          r_next.tick = 4'h0;
          step        = 1'b1;
          // Phase wraps after duty+1 backplanes
          if (r_reg.phase == duty) begin                       // see R19
            r_next.phase = 3'h0;
            frame_start  = 1'b1;
          end else begin
            r_next.phase = r_reg.phase + 3'h1;
          end
        end else begin
          r_next.tick = r_reg.tick + 4'h1;
        end
      end
    end else begin
      r_next.seg_div = 12'h000;
      r_next.tick    = 4'h0;
      r_next.phase   = 3'h0;
    end

    // Blink timer restarts from the normal half when re-enabled
    if (!flash_on || !drv_on) begin
      r_next.blink_cnt = '0;                                   // see R1
    end else if (seg_tick) begin
      r_next.blink_cnt = r_reg.blink_cnt + BLINK_CNT_W'(1);    // see R5
    end

    // Event set wins over a simultaneous write-1 clear
    r_next.flag = (r_reg.flag & ~flag_clr) |
                  (frame_start & frame_event_irq_enable);      // see R20
    r_next.irq  = r_next.flag & r_next.config_b[IRQ_EN_BIT];   // see R23

    // Pattern scan: one pin per cycle, memory answers one cycle later
    if (step) begin
      r_next.scan_busy  = 1'b1;
      r_next.scan_cnt   = 7'h00;
      r_next.scan_bit   = show_alt ? (r_next.phase + ALT_PHASE_OFS)
                                   : r_next.phase;             // see R15
      r_next.scan_blank = show_blank;
    end else if (r_reg.scan_busy) begin
      if (r_reg.scan_cnt != 7'h00 && r_reg.scan_cnt != 7'h41) begin
        // Same bit drives frontplane segment or backplane activity
        r_next.shadow[cap_pin] =
          mem_port.scan_rdata[r_reg.scan_bit];                 // see R13 R14
      end
      if (r_reg.scan_cnt == 7'h41) begin
        r_next.scan_busy = 1'b0;
        r_next.out_level = lvl_vec;                            // see R3
      end else begin
        r_next.scan_cnt = r_reg.scan_cnt + 7'h01;
      end
    end

    // Pin roles only reach the pins while the driver is on
    r_next.out_lcd = lcd_vec;                                  // see R7 R8
    r_next.out_bp  = bp_vec;                                   // see R9 R8
    if (!drv_on) begin
      r_next.out_level = PIN_VEC_RST;                          // see R8
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Pin and select vectors change only on bus writes, so they ride
  // through any stop that keeps power and reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg            <= '0;
      r_reg.bus        <= BUS_IDLE;
      r_reg.hready     <= 1'b1;
      r_reg.blink_ctrl <= BLINK_CTRL_RST;
      r_reg.config_b   <= CONFIG_RST;                          // see R19
      r_reg.pen        <= PIN_VEC_RST;                         // see R17
      r_reg.bps        <= PIN_VEC_RST;                         // see R18
    end else begin
      r_reg <= r_next;
    end
  end

  assign hreadyout      = r_reg.hready;
  assign hrdata         = r_reg.rdata;
  assign hresp          = r_reg.hresp;
  assign pin_lcd_active = r_reg.out_lcd;
  assign pin_backplane  = r_reg.out_bp;
  assign pin_level      = r_reg.out_level;
  assign drive_phase    = r_reg.phase;
  assign frame_irq      = r_reg.irq;

endmodule

// file: sim/lcd_ctrl_checker.sv
// Bus and pin assertions for the segment LCD control block
module lcd_ctrl_checker
  import lcd_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic [63:0] pin_lcd_active,
  input wire logic [63:0] pin_backplane,
  input wire logic [63:0] pin_level,
  input wire logic [2:0]  drive_phase,
  input wire logic        frame_irq
);
  logic       take;
  logic [3:0] wr_sh;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  assign take = hsel & hready & (htrans == HTRANS_NONSEQ);

  // Recent writes; outputs may only move this soon after one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_sh <= 4'h0;
    end else begin
      wr_sh <= {wr_sh[2:0], take & hwrite};
    end
  end

  // ********
  // Assertions
  // ********
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  chk_read_wait: assert property (take && !hwrite |=>
    !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  chk_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  chk_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_bp_subset: assert property (
    (pin_backplane & ~pin_lcd_active) == 64'h0)
    else $error("backplane on a pin outside the display");
  chk_pin_retain: assert property (
    $changed(pin_lcd_active) || $changed(pin_backplane) |-> |wr_sh)
    else $error("pin setup changed without a write");
  chk_irq_fall: assert property ($fell(frame_irq) |-> |wr_sh)
    else $error("frame interrupt dropped without a write");
  chk_irq_frame: assert property (
    $rose(frame_irq) |-> drive_phase == 3'h0)
    else $error("frame interrupt away from frame start");

  cover property ($rose(frame_irq));
  cover property (take && !hwrite);
  cover property (pin_backplane != 64'h0);
endmodule

bind segment_lcd_blink_pattern_ctrl lcd_ctrl_checker u_lcd_ctrl_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .pin_lcd_active(pin_lcd_active), .pin_backplane(pin_backplane),
  .pin_level(pin_level), .drive_phase(drive_phase),
  .frame_irq(frame_irq));

// file: sim/lcd_glass_model.sv
// Behavioural glass panel: which frontplane segments are lit this phase
module lcd_glass_model (
  input  wire logic [63:0] pin_lcd_active,
  input  wire logic [63:0] pin_backplane,
  input  wire logic [63:0] pin_level,
  output logic [63:0]      seg_lit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic bp_live;

  // A segment conducts only with a live backplane behind it
  assign bp_live = |(pin_lcd_active & pin_backplane & pin_level);
  assign seg_lit = pin_lcd_active & ~pin_backplane & pin_level
                   & {64{bp_live}};
endmodule

// file: sim/tb.sv
// Self-checking bench for the segment LCD control block
module tb
  import lcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [63:0] v;
    int          k;
  } note_t;
  note_t       q[$];
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          smp_k = 0;
  logic        smp = 1'b0;
  logic        rd_dp = 1'b0;
  logic [7:0]  v;
  logic [5:0]  n;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic [63:0] pin_lcd_active;
  logic [63:0] pin_backplane;
  logic [63:0] pin_level;
  logic [63:0] seg_lit;
  logic [2:0]  drive_phase;
  logic        frame_irq;

  always #5 hclk = ~hclk;

  segment_lcd_blink_pattern_ctrl u_segment_lcd_blink_pattern_ctrl (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .pin_lcd_active(pin_lcd_active),
    .pin_backplane(pin_backplane), .pin_level(pin_level),
    .drive_phase(drive_phase), .frame_irq(frame_irq));

  lcd_glass_model u_lcd_glass_model (
    .pin_lcd_active(pin_lcd_active), .pin_backplane(pin_backplane),
    .pin_level(pin_level), .seg_lit(seg_lit));

  // ********
  // Bus master and scoreboard
  // ********
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    q.push_back('{{56'h0, e}, 0});
    bus(1'b0, a, 8'h00);
  endtask

  // Kinds: 1 active, 2 backplane, 3 level, 4 lit, 5 phase, else irq
  task automatic chk(input logic [63:0] e, input int k);
    q.push_back('{e, k});
    smp_k <= k;
    smp <= 1'b1;
    @(posedge hclk);
    smp <= 1'b0;
    @(posedge hclk);
  endtask

  task automatic take(input logic [63:0] o);
    note_t t;
    t = q.pop_front();
    tests_run++;
    if (t.v !== o) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, o, t.v);
    end
  endtask

  always @(posedge hclk) begin
    if (hreadyout === 1'b1)
      rd_dp <= hsel & (htrans == HTRANS_NONSEQ) & !hwrite;
    if (rd_dp && hreadyout === 1'b1)
      take({32'h0, hrdata});
    if (smp)
      case (smp_k)
        1: take(pin_lcd_active);
        2: take(pin_backplane);
        3: take(pin_level);
        4: take(seg_lit);
        5: take({61'h0, drive_phase});
        default: take({63'h0, frame_irq});
      endcase
  end

  // Frame start shows as the interrupt; the scan needs some 66 cycles more
  task automatic frame();
    int i;
    i = 0;
    while (frame_irq !== 1'b1 && i < 26000) begin
      @(posedge hclk);
      i++;
    end
    if (i == 26000) begin
      n_mismatch++;
      $display("[FAIL] %0t no frame start", $time);
    end
    repeat (80) @(posedge hclk);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      $display("[FAIL] %0t run timed out", $time);
      test_done();
    end
  end

  // ********
  // Tests
  // ********
  initial begin
    void'($urandom(61));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFS_BLINK, 8'h00);
    rd(OFS_STATUS, 8'h00);
    rd(OFS_CONFIG, 8'h03);
    rd(12'h020, 8'h00);
    rd(12'h040, 8'h00);
    rd(12'h0FC, 8'h00);
    $display("test reset done");
    v = 8'($urandom) & 8'hEF;
    bus(1'b1, OFS_BLINK, v);
    rd(OFS_BLINK, v);
    bus(1'b1, OFS_BLINK, 8'h00);
    repeat (4) begin
      n = 6'($urandom_range(63, 4));
      v = 8'($urandom);
      bus(1'b1, 12'h100 + {4'h0, n, 2'b00}, v);
      rd(12'h100 + {4'h0, n, 2'b00}, v);
    end
    $display("test readback done");
    bus(1'b1, 12'h100, 8'h11);
    bus(1'b1, 12'h104, 8'h01);
    bus(1'b1, 12'h108, 8'h00);
    bus(1'b1, 12'h10C, 8'hFE);
    bus(1'b1, 12'h020, 8'h0F);
    bus(1'b1, 12'h040, 8'h01);
    chk(64'h0, 1);
    chk(64'h0, 2);
    bus(1'b1, OFS_CONFIG, 8'hC0);
    repeat (4) @(posedge hclk);
    chk(64'hF, 1);
    chk(64'h1, 2);
    frame();
    rd(OFS_STATUS, 8'h80);
    bus(1'b1, OFS_STATUS, 8'h00);
    rd(OFS_STATUS, 8'h80);
    chk(64'h3, 3);
    chk(64'h2, 4);
    chk(64'h0, 5);
    bus(1'b1, OFS_STATUS, 8'h80);
    rd(OFS_STATUS, 8'h00);
    repeat (4) @(posedge hclk);
    chk(64'h0, 6);
    $display("test frame done");
    bus(1'b1, OFS_BLINK, 8'h40);
    frame();
    chk(64'h9, 3);
    chk(64'h8, 4);
    bus(1'b1, OFS_STATUS, 8'h80);
    bus(1'b1, OFS_BLINK, 8'h20);
    frame();
    chk(64'h1, 3);
    chk(64'h0, 4);
    $display("test modes done");
    test_done();
  end
endmodule
